// ==== shared/aprp_pkg.sv ====
/*
 Package for the parallel result read port: widths, result codes,
 the bus fill value, timing constants and the carrier structs.
 Assumes a 50 MHz system clock.
*/
package aprp_pkg;
   // ----------------------------------------
   // Widths and codes
   // ----------------------------------------
   localparam int          RES_W      = 18;
   localparam int          CODE_SPAN  = 262144;
   localparam logic [17:0] CODE_ZERO  = 18'h00000;
   localparam logic [17:0] CODE_FULL  = 18'h3ffff;
   localparam logic [17:0] CODE_MID   = 18'h20000;
   localparam logic [17:0] BUS_ONES   = 18'h3ffff;
   localparam logic [1:0]  INIT_CONVS = 2'h3;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int CONV_TIME_NS  = 1520;
   localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int QUIET_PRE_NS  = 125;
   localparam int QUIET_POST_NS = 40;
   localparam int QUIET_POST_CYC =
      (QUIET_POST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic byte_select;
      logic low_bits_select;
   } aprp_rd_ctl_t;

   typedef struct packed {
      logic [17:0] dout;
      logic [17:0] oe;
   } aprp_bus_t;
endpackage : aprp_pkg

// ==== hdl/aprp_mux.sv ====
/*
 Word select for the result bus: maps the held 18-bit result onto the
 pins for each combination of the two width selects.
 Assumes the result word is stable between conversions.
*/
module aprp_mux
   import aprp_pkg::*;
(
   input  wire logic [17:0] result,
   input  wire logic        byte_select,
   input  wire logic        low_bits_select,
   output logic      [17:0] pins
);
   // ----------------------------------------
   // Select table
   // ----------------------------------------
   // Unused pins are forced to one so a narrow host never sees stale bits
   always_comb begin
      pins = BUS_ONES; // RULE_11
      case ({byte_select, low_bits_select})
         2'h0: pins = result; // RULE_05
         2'h1: pins[3:2] = result[1:0]; // RULE_07
         2'h2: pins[17:10] = result[9:2]; // RULE_09
         2'h3: pins[11:10] = result[1:0]; // RULE_10
         default: pins = BUS_ONES;
      endcase
   end
endmodule : aprp_mux

// ==== hdl/aprp_port.sv ====
/*
 Parallel result read port of an 18-bit converter: conversion timing,
 busy flag, initialization count, result hold and three-state bus.
 Assumes all pin inputs are synchronous to clock; the analog core
 presents an unsigned sample code on sample_code.
*/
// Overview of operation
// (RULE_01) Result is unsigned straight binary, zero to all ones.
// (RULE_02) One code step equals reference over 262144.
// (RULE_03) Bus driven only while select and read strobe both low.
// (RULE_04) Host avoids reads from 125 ns before to 40 ns after start.
// (RULE_05) Both selects low present full 18-bit result.
// (RULE_06) Sixteen-bit host reads twice: both low, then low-bits high.
// (RULE_07) Low-bits high alone puts two low bits on pins 3 and 2.
// (RULE_08) Eight-bit host reads three times with the select steps given.
// (RULE_09) Byte high alone puts bits 9..2 on pins 17..10.
// (RULE_10) Both selects high put two low bits on pins 11 and 10.
// (RULE_11) Pins without selected bits drive one.
// (RULE_12) Eight-bit host may skip the third read.
// (RULE_13) Reads work with toggled strobe or strobe held low.
// (RULE_14) Host must not tie the read strobe low permanently.
// (RULE_15) Host runs three full conversions with reads after power-on.
// (RULE_16) First three conversions after power-on are flagged invalid; code raises result_valid as the third result loads.
// (RULE_17) Host starts conversion with start low 20 ns while selected.
// (RULE_18) Busy rises after start edge, falls when result completes.
// (RULE_19) Presented data is the last completed result, held until next.
// (RULE_20) Host settles selects before sampling each word.
module aprp_port
   import aprp_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYCLES
)(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              conversion_start_n,
   input  wire aprp_pkg::aprp_rd_ctl_t ctl,
   input  wire logic [17:0]       sample_code,
   output logic                   busy,
   output logic                   result_valid,
   output logic                   quiet_violation,
   output aprp_pkg::aprp_bus_t    result_bus_pins
);
   typedef enum logic [0:0] {
      APRP_IDLE = 1'b0,
      APRP_CONV = 1'b1
   } aprp_state_t;

   aprp_state_t state_r;
   logic        start_d_r;
   logic        start_fall;
   logic [11:0] cnt_r;
   logic [17:0] hold_r;
   logic [17:0] result_word_bits;
   logic [1:0]  init_r;
   logic [2:0]  post_r;
   logic        reading;
   logic [17:0] pins;

   // ----------------------------------------
   // Start edge
   // ----------------------------------------
   assign start_fall = start_d_r & ~conversion_start_n & ~ctl.cs_n;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         start_d_r <= 1'b1;
      end else begin
         start_d_r <= conversion_start_n;
      end
   end

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   // Starts during a conversion are ignored; the core cannot resample
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= APRP_IDLE;
         cnt_r   <= 12'h000;
      end else begin
         case (state_r)
            APRP_IDLE: begin
               if (start_fall) begin
                  state_r <= APRP_CONV; // RULE_18
                  cnt_r   <= 12'(CONV_CYC - 1);
               end
            end
            APRP_CONV: begin
               if (cnt_r == 12'h000) begin
                  state_r <= APRP_IDLE; // RULE_18
               end else begin
                  cnt_r <= cnt_r - 12'h001;
               end
            end
            default: state_r <= APRP_IDLE;
         endcase
      end
   end

   assign busy = (state_r == APRP_CONV); // RULE_18

   // ----------------------------------------
   // Result hold and initialization count
   // ----------------------------------------
   // Code is taken as straight binary; full scale spans CODE_SPAN steps
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hold_r <= CODE_ZERO;
      end else if (busy && cnt_r == 12'h000) begin
         hold_r <= sample_code; // RULE_01 RULE_02 RULE_19
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         init_r <= 2'h0;
      end else if (busy && cnt_r == 12'h000 && init_r != INIT_CONVS) begin
         init_r <= init_r + 2'h1; // RULE_16
      end
   end

   assign result_valid     = (init_r == INIT_CONVS); // RULE_16
   assign result_word_bits = hold_r;

   // ----------------------------------------
   // Quiet zone watch after the start edge
   // ----------------------------------------
   // Only the post-edge part is visible; the pre-edge part is host duty
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         post_r <= 3'h0;
      end else if (start_fall) begin
         post_r <= 3'(QUIET_POST_CYC);
      end else if (post_r != 3'h0) begin
         post_r <= post_r - 3'h1;
      end
   end

   assign reading         = ~ctl.cs_n & ~ctl.rd_n;
   assign quiet_violation = reading && (post_r != 3'h0); // RULE_04

   // ----------------------------------------
   // Output bus
   // ----------------------------------------
   aprp_mux u_mux (
      .result          (result_word_bits),
      .byte_select     (ctl.byte_select),
      .low_bits_select (ctl.low_bits_select),
      .pins            (pins)
   );

   // Combinational so the bus follows select changes with strobe held
   assign result_bus_pins.dout = pins; // RULE_13
   assign result_bus_pins.oe   = {RES_W{reading}}; // RULE_03

   // ----------------------------------------
   // Check helper
   // ----------------------------------------
   // Busy length is counted, not unrolled, so long conversions stay cheap
   logic [11:0] busy_len_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy_len_r <= 12'h000;
      end else if (busy) begin
         busy_len_r <= busy_len_r + 12'h001;
      end else begin
         busy_len_r <= 12'h000;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   bus_enable_a: assert property ( // RULE_03
      @(posedge clock) disable iff (rst)
      result_bus_pins.oe[0] == (~ctl.cs_n & ~ctl.rd_n))
      else $error("bus enable wrong");
   bus_off_a: assert property ( // RULE_03
      @(posedge clock) disable iff (rst)
      (ctl.cs_n || ctl.rd_n) |-> result_bus_pins.oe == {RES_W{1'b0}})
      else $error("bus driven while not read");
   busy_rise_a: assert property ( // RULE_18
      @(posedge clock) disable iff (rst)
      (start_fall && !busy) |=> busy)
      else $error("busy did not rise");
   busy_len_a: assert property ( // RULE_18
      @(posedge clock) disable iff (rst)
      $rose(busy) |-> busy [*8])
      else $error("busy too short");
   busy_count_a: assert property ( // RULE_18
      @(posedge clock) disable iff (rst)
      $fell(busy) |-> busy_len_r == 12'(CONV_CYC))
      else $error("busy length wrong");
   busy_keep_a: assert property ( // RULE_18
      @(posedge clock) disable iff (rst)
      (busy && cnt_r != 12'h000) |=> busy)
      else $error("busy fell early");
   busy_end_a: assert property ( // RULE_18
      @(posedge clock) disable iff (rst)
      (busy && cnt_r == 12'h000) |=> !busy)
      else $error("busy did not fall");
   busy_idle_a: assert property ( // RULE_18
      @(posedge clock) disable iff (rst)
      (!busy && !start_fall) |=> !busy)
      else $error("busy without start");
   hold_stable_a: assert property ( // RULE_19
      @(posedge clock) disable iff (rst)
      !(busy && cnt_r == 12'h000) |=> $stable(hold_r))
      else $error("result changed");
   hold_load_a: assert property ( // RULE_19
      @(posedge clock) disable iff (rst)
      (busy && cnt_r == 12'h000) |=> hold_r == $past(sample_code))
      else $error("result not loaded");
   full_word_a: assert property ( // RULE_05
      @(posedge clock) disable iff (rst)
      (!ctl.byte_select && !ctl.low_bits_select) |-> pins == hold_r)
      else $error("full word wrong");
   low_two_a: assert property ( // RULE_07
      @(posedge clock) disable iff (rst)
      (!ctl.byte_select && ctl.low_bits_select) |->
      pins == {14'h3fff, hold_r[1:0], 2'h3})
      else $error("low bits wrong");
   mid_octet_a: assert property ( // RULE_09
      @(posedge clock) disable iff (rst)
      (ctl.byte_select && !ctl.low_bits_select) |->
      pins == {hold_r[9:2], 10'h3ff})
      else $error("mid octet wrong");
   byte_low_a: assert property ( // RULE_10
      @(posedge clock) disable iff (rst)
      (ctl.byte_select && ctl.low_bits_select) |->
      pins == {6'h3f, hold_r[1:0], 10'h3ff})
      else $error("byte low wrong");
   init_valid_a: assert property ( // RULE_16
      @(posedge clock) disable iff (rst)
      result_valid |=> result_valid)
      else $error("valid dropped");
   valid_rise_a: assert property ( // RULE_16
      @(posedge clock) disable iff (rst)
      $rose(result_valid) |-> $past(busy))
      else $error("valid rose outside a conversion");
   quiet_arm_a: assert property ( // RULE_04
      @(posedge clock) disable iff (rst)
      start_fall |=> post_r != 3'h0)
      else $error("quiet window not armed");
   quiet_clear_a: assert property ( // RULE_04
      @(posedge clock) disable iff (rst)
      (post_r == 3'h0) |-> !quiet_violation)
      else $error("quiet flag outside window");
endmodule : aprp_port

// ==== verif/aprp_host.sv ====
/*
 Host model: start pulses and read strobes for the result port.
 Assumes the port samples its inputs at the rising clock edge.
*/
module aprp_host (
   input  wire logic              clock,
   output logic                   conversion_start_n,
   output aprp_pkg::aprp_rd_ctl_t ctl
);
   timeunit 1ns;
   timeprecision 1ps;
   import aprp_pkg::*;
   // ----------------------------------------
   // Host timing
   // ----------------------------------------
   initial begin
      conversion_start_n = 1'b1;
      ctl = 4'hc;
   end
   // Strobe kept high around the edge so no read lands in the quiet zone
   task automatic start(input logic sel_n);
      @(posedge clock);
      ctl.rd_n <= 1'b1;
      ctl.cs_n <= sel_n;
      repeat (7) @(posedge clock);
      conversion_start_n <= 1'b0;
      @(posedge clock);
      conversion_start_n <= 1'b1;
      repeat (2) @(posedge clock);
   endtask : start
   task automatic read(input aprp_rd_ctl_t c);
      @(posedge clock);
      ctl <= c;
      repeat (2) @(posedge clock);
   endtask : read
   // Read held across the start edge; used only to trip the quiet flag
   task automatic start_in_read;
      @(posedge clock);
      ctl <= 4'h0;
      conversion_start_n <= 1'b0;
      @(posedge clock);
      conversion_start_n <= 1'b1;
   endtask : start_in_read
endmodule : aprp_host

// ==== verif/tb_top.sv ====
/*
 Testbench for the result read port: word selects, bus enable,
 conversion timing, result hold and the power-on count.
 Assumes a host model that drives the start and control inputs.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import aprp_pkg::*;
   typedef struct packed {
      logic [17:0] code;
      logic [3:0]  c;
      logic [17:0] d;
      logic        en;
   } aprp_row_t;
   // ----------------------------------------
   // Signals and rows
   // ----------------------------------------
   logic         clock, rst, busy, result_valid, quiet_violation;
   logic         conversion_start_n, qv = 1'b0;
   aprp_rd_ctl_t ctl;
   logic [17:0]  sample_code, lc;
   aprp_bus_t    pins;
   int           failures = 0, n_checks = 0, cyc = 0, nb = 0, k;
   aprp_row_t    rows [13] = '{
      {18'h3ffff, 4'h0, 18'h3ffff, 1'b1},
      {18'h20000, 4'h0, 18'h20000, 1'b1},
      {18'h1ffff, 4'h0, 18'h1ffff, 1'b1},
      {18'h00000, 4'h0, 18'h00000, 1'b1},
      {18'h00000, 4'h1, 18'h3fff3, 1'b1},
      {18'h00000, 4'h2, 18'h003ff, 1'b1},
      {18'h00000, 4'h3, 18'h3f3ff, 1'b1},
      {18'h2abcd, 4'h0, 18'h2abcd, 1'b1},
      {18'h2abcd, 4'h2, 18'h3cfff, 1'b1},
      {18'h2abcd, 4'h3, 18'h3f7ff, 1'b1},
      {18'h2abcd, 4'h1, 18'h3fff7, 1'b1},
      {18'h2abcd, 4'h8, 18'h00000, 1'b0},
      {18'h2abcd, 4'h4, 18'h00000, 1'b0}};

   aprp_port #(.CONV_CYC(16)) u_aprp_port (.clock(clock), .rst(rst),
      .conversion_start_n(conversion_start_n), .ctl(ctl),
      .sample_code(sample_code), .busy(busy), .result_valid(result_valid),
      .quiet_violation(quiet_violation), .result_bus_pins(pins));
   aprp_host u_host (.clock(clock),
      .conversion_start_n(conversion_start_n), .ctl(ctl));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (busy === 1'b1) nb <= nb + 1;
      if (quiet_violation === 1'b1) qv <= 1'b1;
      if (cyc == 4000) begin
         failures = failures + 1;
         finish_test();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [17:0] s, e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wait_idle;
      for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clock);
   endtask : wait_idle
   task automatic conv(input logic [17:0] c);
      sample_code <= c;
      k = nb;
      u_host.start(1'b0);
      wait_idle();
      chk("busy cycles", 18'(nb - k), 18'h10);
   endtask : conv
   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      sample_code = 18'h00000;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk("oe reset", pins.oe, 18'h0);
      for (int i = 0; i < 3; i++) begin
         chk("valid", {17'h0, result_valid}, 18'h0);
         conv(18'h0);
         u_host.read(4'h0);
      end
      @(negedge clock);
      chk("valid", {17'h0, result_valid}, 18'h1);
      lc = 18'h3;
      foreach (rows[i]) begin
         if (rows[i].code !== lc) conv(rows[i].code);
         lc = rows[i].code;
         u_host.read(rows[i].c);
         @(negedge clock);
         chk("oe", pins.oe, {18{rows[i].en}});
         if (rows[i].en) chk("dout", pins.dout, rows[i].d);
      end
      u_host.start(1'b1);
      @(negedge clock);
      chk("busy unselected", {17'h0, busy}, 18'h0);
      sample_code <= 18'h0aaaa;
      k = nb;
      u_host.start(1'b0);
      u_host.read(4'h0);
      @(negedge clock);
      chk("held", pins.dout, 18'h2abcd);
      u_host.start(1'b0);
      wait_idle();
      chk("busy restart", 18'(nb - k), 18'h10);
      u_host.read(4'h0);
      @(negedge clock);
      chk("busy after", {17'h0, busy}, 18'h0);
      chk("new", pins.dout, 18'h0aaaa);
      chk("quiet", {17'h0, qv}, 18'h0);
      u_host.start_in_read();
      @(negedge clock);
      chk("quiet flag", {17'h0, quiet_violation}, 18'h1);
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk("busy reset", {17'h0, busy}, 18'h0);
      chk("valid reset", {17'h0, result_valid}, 18'h0);
      chk("dout reset", pins.dout, 18'h0);
      finish_test();
   end
endmodule : tb_top
